// *** rtl/ddt_pkg.sv ***
// Package with register map and constants of the dual down counter timer
package ddt_pkg;
  // Register byte offsets, per counter block of 0x20
  localparam logic [7:0] DDT_CNT_STRIDE = 8'h20;
  localparam logic [4:0] DDT_LOAD_OFF   = 5'h00;
  localparam logic [4:0] DDT_VALUE_OFF  = 5'h04;
  localparam logic [4:0] DDT_CTRL_OFF   = 5'h08;
  localparam logic [4:0] DDT_ICLR_OFF   = 5'h0c;
  localparam logic [4:0] DDT_RIS_OFF    = 5'h10;
  localparam logic [4:0] DDT_MIS_OFF    = 5'h14;
  localparam logic [4:0] DDT_BGLOAD_OFF = 5'h18;
  // Control field positions
  localparam int DDT_CTRL_ONESHOT = 0;
  localparam int DDT_CTRL_SIZE32  = 1;
  localparam int DDT_CTRL_PRE_LO  = 2;
  localparam int DDT_CTRL_IE      = 5;
  localparam int DDT_CTRL_PERIOD  = 6;
  localparam int DDT_CTRL_EN      = 7;
  // Reset values
  localparam logic [7:0]  DDT_CTRL_RST  = 8'h20;
  localparam logic [31:0] DDT_LOAD_RST  = 32'h0000_0000;
  localparam logic [31:0] DDT_VALUE_RST = 32'hffff_ffff;
  // Prescaler select codes and terminal counts
  localparam logic [1:0] DDT_PRE_DIV1   = 2'h0;
  localparam logic [1:0] DDT_PRE_DIV16  = 2'h1;
  localparam logic [1:0] DDT_PRE_DIV256 = 2'h2;
  localparam logic [7:0] DDT_PRE_TC16   = 8'h0f;
  localparam logic [7:0] DDT_PRE_TC256  = 8'hff;
  localparam logic [31:0] DDT_MASK16    = 32'h0000_ffff;
endpackage

// *** rtl/ddt_cnt_if.sv ***
// Interface between the register file and one down counter
`timescale 1ns/1ps
`default_nettype none
interface ddt_cnt_if;
  logic        load_we;
  logic        bg_we;
  logic [31:0] wdata;
  logic [7:0]  ctrl;
  logic        ctrl_we;
  logic        oneshot_cleared;
  logic [31:0] value;
  logic        zero_evt;
  modport regs (output load_we, output bg_we, output wdata, output ctrl,
                output ctrl_we, output oneshot_cleared,
                input value, input zero_evt);
  modport cnt  (input load_we, input bg_we, input wdata, input ctrl,
                input ctrl_we, input oneshot_cleared,
                output value, output zero_evt);
endinterface
`default_nettype wire

// *** rtl/ddt_counter.sv ***
// One prescaled down counter with one-shot, free-running and periodic modes
`timescale 1ns/1ps
`default_nettype none
module ddt_counter
  import ddt_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Register side
  ddt_cnt_if.cnt    cif
);
  typedef struct packed {
    logic [7:0]  pre;
    logic [31:0] cnt;
    logic [31:0] reload;
    logic        halted;
    logic        zero;
  } ddt_cnt_st_t;

  ddt_cnt_st_t s_q, s_d;
  logic [31:0] wmask;
  logic        tick;
  logic        size32;
  logic        at_zero;

  always_comb begin
    s_d     = s_q;
    size32  = cif.ctrl[DDT_CTRL_SIZE32];
    wmask   = size32 ? 32'hffff_ffff : DDT_MASK16; // [RULE15] [RULE2]
    at_zero = ((s_q.cnt & wmask) == 32'h0000_0000); // [RULE15]
    tick    = 1'b0;
    s_d.zero = 1'b0;
    if (cif.ctrl[DDT_CTRL_EN] && !s_q.halted) begin // [RULE1] [RULE6]
      unique case (cif.ctrl[DDT_CTRL_PRE_LO +: 2]) // [RULE3]
        DDT_PRE_DIV16:  tick = (s_q.pre[3:0] == DDT_PRE_TC16[3:0]);
        DDT_PRE_DIV256: tick = (s_q.pre == DDT_PRE_TC256);
        default:        tick = 1'b1;
      endcase
      s_d.pre = s_q.pre + 8'h01; // [RULE4]
    end
    if (tick) begin
      if (at_zero) begin
        if (cif.ctrl[DDT_CTRL_ONESHOT]) begin
          s_d.halted = 1'b1; // [RULE7]
        end else if (cif.ctrl[DDT_CTRL_PERIOD]) begin
          s_d.cnt = s_q.reload & wmask; // [RULE9] [RULE11]
        end else begin
          s_d.cnt = wmask; // [RULE8]
        end
      end else begin
        s_d.cnt = (s_q.cnt - 32'h0000_0001) & wmask; // [RULE6]
        s_d.zero = ((s_d.cnt & wmask) == 32'h0000_0000); // [RULE12]
      end
    end
    if (cif.ctrl_we && cif.oneshot_cleared) begin
      s_d.halted = 1'b0; // [RULE7]
    end
    if (cif.bg_we) begin
      s_d.reload = cif.wdata; // [RULE11]
    end
    if (cif.load_we) begin
      s_d.reload = cif.wdata;
      s_d.cnt    = cif.wdata & wmask; // [RULE10]
      s_d.pre    = 8'h00;
      s_d.halted = 1'b0; // [RULE7]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{pre: 8'h00, cnt: DDT_VALUE_RST, reload: DDT_LOAD_RST,
               halted: 1'b0, zero: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign cif.value    = s_q.cnt & wmask;
  assign cif.zero_evt = s_q.zero;
endmodule
`default_nettype wire

// *** rtl/ddt_top.sv ***
// APB register file and interrupt logic of the dual down counter timer
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1 - Two counters share clock, reset and interrupt; each has an enable.
// RULE2 - A control bit selects 16-bit or 32-bit counter width.
// RULE3 - A prescaler divides the enabled clock by 1, 16 or 256.
// RULE4 - Counting runs on the counting clock, registers on the bus clock; here both run on SYS_CLK_I.
// RULE5 - Both clocks are synchronous, so no crossing logic is used.
// RULE6 - Writing load sets the count; counting happens only while enabled.
// RULE7 - One-shot interrupts once at zero, holds until cleared or reloaded.
// RULE8 - Free-running, the reset mode, wraps from zero to the width maximum.
// RULE9 - Periodic mode reloads the load value after zero.
// RULE10 - A load write while running restarts counting from the new value.
// RULE11 - A background load write only sets the next periodic reload value.
// RULE12 - Reaching zero sets a raw flag that stays until a clear write.
// RULE13 - An enable bit masks the interrupt; raw and masked status are read.
// RULE14 - Both masked interrupts are ORed onto one output.
// RULE15 - In 16-bit mode only the low half counts, wraps and detects zero.
// RULE16 - Any clear register write clears the raw flag and stores nothing.
module ddt_top
  import ddt_pkg::*;
#(
  parameter int NCNT = 2
) (
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Combined interrupt
  output logic             IRQ_O
);
  typedef struct packed {
    logic [NCNT-1:0][7:0] ctrl;
    logic [NCNT-1:0]      raw;
    logic [31:0]          rdata;
  } ddt_top_st_t;

  ddt_top_st_t s_q, s_d;
  ddt_cnt_if cif [NCNT] ();
  logic [NCNT-1:0]       zero_evt;
  logic [NCNT-1:0][31:0] value;
  logic                  access;
  logic                  wr;
  logic [2:0]            sel;
  logic [4:0]            off;
  logic [NCNT-1:0]       masked;

  assign access = PSEL_I && PENABLE_I;
  assign wr     = access && PWRITE_I;
  assign sel    = PADDR_I[7:5];
  assign off    = PADDR_I[4:0];

  // Counters on the same clock, no synchronisers needed
  for (genvar i = 0; i < NCNT; i++) begin : g_cnt
    assign cif[i].wdata   = PWDATA_I;
    assign cif[i].ctrl    = s_q.ctrl[i];
    assign cif[i].load_we = wr && (sel == 3'(i)) &&
                            (off == DDT_LOAD_OFF); // [RULE6] [RULE10]
    assign cif[i].bg_we   = wr && (sel == 3'(i)) &&
                            (off == DDT_BGLOAD_OFF); // [RULE11]
    assign cif[i].ctrl_we = wr && (sel == 3'(i)) && (off == DDT_CTRL_OFF);
    assign cif[i].oneshot_cleared = !PWDATA_I[DDT_CTRL_ONESHOT]; // [RULE7]
    assign zero_evt[i] = cif[i].zero_evt;
    assign value[i]    = cif[i].value;
    assign masked[i]   = s_q.raw[i] && s_q.ctrl[i][DDT_CTRL_IE]; // [RULE13]
    ddt_counter u_cnt (
      .clk_i (SYS_CLK_I), // [RULE4] [RULE5]
      .rst_i (RST_I),
      .cif   (cif[i])
    );
  end

  always_comb begin
    s_d        = s_q;
    if (PSEL_I && !PENABLE_I) begin
      s_d.rdata = 32'h0000_0000;
      if (!PWRITE_I && sel < 3'(NCNT)) begin
        for (int i = 0; i < NCNT; i++) begin
          if (sel == 3'(i)) begin
            unique case (off)
              DDT_LOAD_OFF, DDT_BGLOAD_OFF: s_d.rdata = value[i];
              DDT_VALUE_OFF: s_d.rdata = value[i];
              DDT_CTRL_OFF:  s_d.rdata = {24'h000000, s_q.ctrl[i]};
              DDT_RIS_OFF:   s_d.rdata = {31'h0, s_q.raw[i]}; // [RULE13]
              DDT_MIS_OFF:   s_d.rdata = {31'h0, masked[i]}; // [RULE13]
              default:       s_d.rdata = 32'h0000_0000;
            endcase
          end
        end
      end
    end
    for (int i = 0; i < NCNT; i++) begin
      if (wr && sel == 3'(i) && off == DDT_CTRL_OFF) begin
        s_d.ctrl[i] = PWDATA_I[7:0]; // [RULE2] [RULE3]
      end
      if (wr && sel == 3'(i) && off == DDT_ICLR_OFF) begin
        s_d.raw[i] = 1'b0; // [RULE16]
      end
      if (zero_evt[i]) begin
        s_d.raw[i] = 1'b1; // [RULE12]
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_q <= '{ctrl: {NCNT{DDT_CTRL_RST}}, raw: '0,
               rdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA_O  = s_q.rdata;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = access && (sel >= 3'(NCNT));
  assign IRQ_O     = |masked; // [RULE14]
endmodule
`default_nettype wire

// *** dv/ddt_top_chk.sv ***
// Port checker of the dual down counter timer
`timescale 1ns/1ps
`default_nettype none
module ddt_top_chk (
  // Clock, reset and bus
  input wire logic        SYS_CLK_I,
  input wire logic        RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        IRQ_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  wire acc = PSEL_I && PENABLE_I;
  wire bad = acc && PADDR_I >= 8'h40;
  wire rd  = acc && !PWRITE_I && !bad;
  AST_RDY: assert property (PREADY_O) else $error("ready low");
  AST_ERR: assert property (bad |-> PSLVERR_O)
    else $error("no err");
  AST_NOERR: assert property (!bad |-> !PSLVERR_O)
    else $error("err");
  AST_ERRD: assert property (bad && !PWRITE_I |-> PRDATA_O == 32'h0)
    else $error("bad read data");
  AST_HOLD: assert property (!$past(PSEL_I && !PENABLE_I) |->
    $stable(PRDATA_O)) else $error("read data moved");
  AST_FALL: assert property ($fell(IRQ_O) |->
    $past(acc && PWRITE_I)) else $error("irq fell alone");
  AST_GAP: assert property (rd && PADDR_I[4:0] == 5'h1c |->
    PRDATA_O == 32'h0) else $error("gap not zero");
  AST_RAW: assert property (rd && PADDR_I[4:0] == 5'h10 |->
    PRDATA_O[31:1] == 31'h0) else $error("raw width");
  AST_MSK: assert property (rd && PADDR_I[4:0] == 5'h14 |->
    PRDATA_O[31:1] == 31'h0 && (!PRDATA_O[0] || IRQ_O))
    else $error("masked vs irq");
endmodule
`default_nettype wire

// *** dv/ddt_apb_bfm.sv ***
// Processor side bus model issuing register transfers
`timescale 1ns/1ps
`default_nettype none
module ddt_apb_bfm (
  // Clock and answer
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  // Request
  output logic             psel_o = 1'b0,
  output logic             penable_o = 1'b0,
  output logic             pwrite_o = 1'b0,
  output logic [7:0]       paddr_o = 8'h0,
  output logic [31:0]      pwdata_o = 32'h0
);
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    psel_o   <= 1'b1;
    pwrite_o <= w;
    paddr_o  <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o  <= ~d;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** dv/ddt_top_test.sv ***
// Self-checking bench of the dual down counter timer
`timescale 1ns/1ps
`default_nettype none
module ddt_top_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel, pen, pwr, prdy, perr, irq;
  logic [7:0]  pa;
  logic [31:0] pwd, prd, q;
  int          n_mismatch = 0;
  int          n_compared = 0;
  always #4 clk = ~clk;
  ddt_top ddt_top_i (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .IRQ_O(irq));
  ddt_apb_bfm ddt_apb_bfm_i (.clk_i(clk), .pready_i(prdy), .prdata_i(prd),
    .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(pa),
    .pwdata_o(pwd));
  task automatic chk(input string s, input logic [31:0] v, e);
    n_compared++;
    if (v !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", s, e, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ddt_apb_bfm_i.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string s);
    ddt_apb_bfm_i.xfer(1'b0, a, 32'h0, q);
    chk(s, q, e);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h08, 32'h20, "ctrl");
    rd(8'h04, 32'hffff, "value");
    rd(8'h44, 32'h0, "bad");
    rd(8'h1c, 32'h0, "gap");
    wr(8'h00, 32'h5);
    rd(8'h04, 32'h5, "idle");
    wr(8'h08, 32'ha1);
    repeat (10) @(posedge clk);
    rd(8'h04, 32'h0, "halt");
    rd(8'h10, 32'h1, "raw");
    chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h08, 32'h81);
    rd(8'h14, 32'h0, "masked");
    rd(8'h10, 32'h1, "kept");
    wr(8'h0c, 32'hdeadbeef);
    rd(8'h10, 32'h0, "clr");
    wr(8'h20, 32'h2);
    wr(8'h28, 32'he8);
    rd(8'h24, 32'h2, "div");
    wr(8'h38, 32'h9);
    rd(8'h24, 32'h2, "bg");
    repeat (800) @(posedge clk);
    rd(8'h24, 32'h9, "reload");
    rd(8'h34, 32'h1, "masked1");
    for (int w = 0; w < 2; w++) begin
      wr(8'h08, 32'h80 | (w << 1));
      wr(8'h00, 32'h1);
      @(posedge clk);
      ddt_apb_bfm_i.xfer(1'b0, 8'h04, 32'h0, q);
      chk("wrap", q, w ? 32'hffff_ffff : 32'h0000_ffff);
    end
    wr(8'h08, 32'h84);
    wr(8'h00, 32'h10);
    rd(8'h04, 32'h10, "pre16a");
    repeat (14) @(posedge clk);
    rd(8'h04, 32'hf, "pre16b");
    print_verdict;
  end
endmodule
bind ddt_top ddt_top_chk ddt_top_chk_i (.SYS_CLK_I(SYS_CLK_I),
  .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O));
`default_nettype wire
